// ==== testbench/dtwbsp_checker.sv ====
// concurrent checks on the pins between the controller end and the sram end
`timescale 1ns/100ps
module dtwbsp_checker (
   // clock and reset
   input wire logic clk_i,
   input wire logic reset_i,
   // pins
   input wire logic sys_timing_true,
   input wire logic sys_timing_comp,
   input wire logic out_timing_true,
   input wire logic out_timing_inv,
   input wire logic bank_select_n,
   input wire logic read_not_write,
   input wire logic write_bits_oe,
   input wire logic read_word_oe,
   input wire logic echo_strobe_true,
   input wire logic echo_strobe_inv
);
   // ------------------------------------------------------------
   // command decode
   // ------------------------------------------------------------
   wire rd_cmd;
   wire wr_cmd;
   assign rd_cmd = sys_timing_true & ~bank_select_n & read_not_write;
   assign wr_cmd = sys_timing_true & ~bank_select_n & ~read_not_write;
   default clocking cb @(posedge clk_i);
   endclocking
   default disable iff (reset_i);
   // ------------------------------------------------------------
   // assertions
   // ------------------------------------------------------------
   a_echo_true_follows: assert property (out_timing_true |=> echo_strobe_true)
      else $error("true echo missing after output clock");
   a_echo_inv_follows: assert property (echo_strobe_inv == $past(out_timing_inv))
      else $error("inverted echo not tracking output clock");
   a_read_word_slot: assert property (rd_cmd |-> ##4 read_word_oe [*2])
      else $error("read words not driven in their slots");
   a_oe_has_cause: assert property ($rose(read_word_oe) |-> $past(rd_cmd, 4))
      else $error("data pins driven without a read");
   a_oe_release: assert property (rd_cmd |-> ##[5:7] !read_word_oe)
      else $error("data pins not released after read");
   a_no_contention: assert property (!(read_word_oe && write_bits_oe))
      else $error("both ends drive the data pins");
   a_write_data_slot: assert property (wr_cmd |-> ##2 (write_bits_oe && sys_timing_true)
      ##1 (write_bits_oe && sys_timing_comp))
      else $error("write words not on the input clock rises");
   a_comp_after_true: assert property (sys_timing_true |=> sys_timing_comp && !sys_timing_true)
      else $error("inverted input clock out of step");
   a_select_in_slot: assert property (!bank_select_n |-> sys_timing_true)
      else $error("select outside a command slot");
   cover property (wr_cmd);
   cover property (rd_cmd);
   cover property (echo_strobe_inv);
endmodule

// ==== testbench/test_ddr_two_word_burst_sram_port.sv ====
// self-checking bench: controller end and sram end face each other
`timescale 1ns/100ps
`define CHECK(nm, exp, act) begin tests_run++; if ((act) !== (exp)) begin failures++; \
   $display("Error %s expected %h seen %h", nm, exp, act); end end
module test_ddr_two_word_burst_sram_port import dtwbsp_pkg::*;;
   logic clk_i = 1'b0;
   logic reset_i = 1'b1;
   logic cmd_valid_i = 1'b0, cmd_write_i = 1'b0, dll_reset_i = 1'b0;
   logic [7:0] cmd_addr_i = 8'h00;
   logic [17:0] cmd_wdata0_i = 18'h00000, cmd_wdata1_i = 18'h00000;
   logic [1:0] cmd_mask0_i = 2'h3, cmd_mask1_i = 2'h3;
   logic cmd_ready_o, rd_valid_o, single_clock_o, dll_locked_o, imp_update_o;
   logic [17:0] rd_data_o;
   logic [17:0] mem [256];
   int failures = 0;
   int tests_run = 0;
   int n;
   dtwbsp_if link ();
   dtwbsp_device dtwbsp_device_i (.clk_i(clk_i), .reset_i(reset_i), .link(link),
      .single_clock_o(single_clock_o), .dll_locked_o(dll_locked_o),
      .imp_update_o(imp_update_o));
   dtwbsp_host dtwbsp_host_i (.clk_i(clk_i), .reset_i(reset_i), .link(link),
      .cmd_valid_i(cmd_valid_i), .cmd_write_i(cmd_write_i), .cmd_addr_i(cmd_addr_i),
      .cmd_wdata0_i(cmd_wdata0_i), .cmd_wdata1_i(cmd_wdata1_i), .cmd_mask0_i(cmd_mask0_i),
      .cmd_mask1_i(cmd_mask1_i), .dll_reset_i(dll_reset_i), .cmd_ready_o(cmd_ready_o),
      .rd_valid_o(rd_valid_o), .rd_data_o(rd_data_o));
   dtwbsp_checker dtwbsp_checker_i (.clk_i(clk_i), .reset_i(reset_i),
      .sys_timing_true(link.sys_timing_true), .sys_timing_comp(link.sys_timing_comp),
      .out_timing_true(link.out_timing_true), .out_timing_inv(link.out_timing_inv),
      .bank_select_n(link.bank_select_n), .read_not_write(link.read_not_write),
      .write_bits_oe(link.write_bits_oe), .read_word_oe(link.read_word_oe),
      .echo_strobe_true(link.echo_strobe_true), .echo_strobe_inv(link.echo_strobe_inv));
   initial begin
      forever #2.5 clk_i = ~clk_i;
   end
   // ------------------------------------------------------------
   // helpers
   // ------------------------------------------------------------
   task automatic summarize();
      $display("comparisons %0d mismatches %0d", tests_run, failures);
      if (failures == 0 && tests_run > 0) begin
         $display("ALL TESTS PASSED");
      end else begin
         $display("TESTS FAILED");
      end
      $finish;
   endtask
   // bounded wait for a level, counting falling edges; running out is a mismatch
   task automatic wait_lvl(ref logic s, input logic v, input int lim, output int k);
      for (k = 1; k <= lim; k++) begin
         @(negedge clk_i);
         if (s === v) return;
      end
      failures++;
      $display("Error wait expected %h seen %h", v, s);
      summarize();
   endtask
   // masked lanes keep the old contents
   function automatic logic [17:0] merge(logic [17:0] o, logic [17:0] d, logic [1:0] m);
      return {m[1] ? o[17:9] : d[17:9], m[0] ? o[8:0] : d[8:0]};
   endfunction
   task automatic issue(input logic w, input logic [7:0] a, input logic [17:0] d0,
      input logic [17:0] d1, input logic [1:0] m0, input logic [1:0] m1);
      int k;
      // one edge apart from the previous drop of valid
      @(posedge clk_i);
      cmd_valid_i <= 1'b1;
      cmd_write_i <= w;
      cmd_addr_i <= a;
      cmd_wdata0_i <= d0;
      cmd_wdata1_i <= d1;
      cmd_mask0_i <= m0;
      cmd_mask1_i <= m1;
      wait_lvl(cmd_ready_o, 1'b1, 20, k);
      @(posedge clk_i);
      cmd_valid_i <= 1'b0;
      if (w) begin
         mem[a] = merge(mem[a], d0, m0);
         mem[a ^ 8'h01] = merge(mem[a ^ 8'h01], d1, m1);
      end
   endtask
   task automatic wr(input logic [7:0] a, input logic [17:0] d0, input logic [17:0] d1,
      input logic [1:0] m0, input logic [1:0] m1);
      issue(1'b1, a, d0, d1, m0, m1);
   endtask
   // both words come back in burst order: base, then base with lsb flipped
   task automatic rd(input logic [7:0] a);
      int k;
      issue(1'b0, a, 18'h00000, 18'h00000, 2'h3, 2'h3);
      wait_lvl(rd_valid_o, 1'b1, 12, k);
      `CHECK("word0", mem[a], rd_data_o)
      @(negedge clk_i);
      `CHECK("word1 valid", 1'b1, rd_valid_o)
      `CHECK("word1", mem[a ^ 8'h01], rd_data_o)
      @(posedge clk_i);
   endtask
   // ------------------------------------------------------------
   // main sequence
   // ------------------------------------------------------------
   initial begin
      repeat (6) @(posedge clk_i);
      reset_i <= 1'b0;
      @(negedge clk_i);
      `CHECK("oe after reset", 1'b0, link.read_word_oe)
      `CHECK("select after reset", 1'b1, link.bank_select_n)
      `CHECK("strap", 1'b0, single_clock_o)
      @(posedge clk_i);
      wr(8'h10, 18'h2a5a5, 18'h15a5a, 2'h0, 2'h0);
      wr(8'h21, 18'h01234, 18'h3abcd, 2'h0, 2'h0);
      rd(8'h10);
      rd(8'h20);
      rd(8'h21);
      $display("test burst done");
      wr(8'h10, 18'h3ffff, 18'h3ffff, 2'h2, 2'h1);
      wr(8'h20, 18'h00000, 18'h00000, 2'h3, 2'h3);
      rd(8'h10);
      rd(8'h20);
      $display("test lane mask done");
      // the last write stays posted until the next write commits it
      wr(8'h30, 18'h11111, 18'h22222, 2'h0, 2'h0);
      rd(8'h30);
      wr(8'h31, 18'h33333, 18'h00000, 2'h0, 2'h2);
      rd(8'h30);
      rd(8'h21);
      // a write pressed right behind a read must wait out the idle slots
      issue(1'b0, 8'h10, 18'h00000, 18'h00000, 2'h3, 2'h3);
      wr(8'h40, 18'h0a0a0, 18'h05050, 2'h0, 2'h0);
      rd(8'h40);
      $display("test posted write done");
      wait_lvl(imp_update_o, 1'b1, 3000, n);
      wait_lvl(imp_update_o, 1'b1, 3000, n);
      `CHECK("impedance interval", IMP_INTERVAL * 2, n)
      $display("test impedance done");
      wait_lvl(dll_locked_o, 1'b1, 40, n);
      @(posedge clk_i);
      dll_reset_i <= 1'b1;
      @(posedge clk_i);
      dll_reset_i <= 1'b0;
      wait_lvl(dll_locked_o, 1'b0, 30, n);
      wait_lvl(dll_locked_o, 1'b1, 60, n);
      @(posedge clk_i);
      rd(8'h10);
      $display("test loop reset done");
      summarize();
   end
endmodule

// ==== verilog/dtwbsp_device.sv ====
// sram end: array, posted write, read pipeline, echo strobes, loop and impedance status
//
`timescale 1ns/100ps
module dtwbsp_device import dtwbsp_pkg::*; #(
   parameter int WORD_W = DEF_WORD_W,
   parameter int LANES = DEF_LANES,
   parameter int ADDR_W = DEF_ADDR_W
) (
   // clock and reset
   input wire logic clk_i,
   input wire logic reset_i,
   // pins
   dtwbsp_if.dev link,
   // status
   output logic single_clock_o,
   output logic dll_locked_o,
   output logic imp_update_o
);
   // lane count and word width are parameters; the lane merge needs the word width to be a multiple of the lane count
   localparam bit WIDE = WORD_W > NARROW_W;
   localparam logic [LANES-1:0] KEEP_ALL = '1;

   // ------------------------------------------------------------
   // strap and clock selection
   // ------------------------------------------------------------
   logic strap_done;
   logic single;
   wire k_t = link.sys_timing_true & strap_done;
   wire k_c = link.sys_timing_comp & strap_done;
   // single-clock mode times outputs and echoes off the input clocks
   wire c_t = single ? k_t : link.out_timing_true;
   wire c_i = single ? k_c : link.out_timing_inv;

   always_ff @(posedge clk_i or posedge reset_i) begin
      if (reset_i) begin
         strap_done <= 1'b0;
         single <= 1'b0;
      end else if (!strap_done) begin
         strap_done <= 1'b1;
         // caught once after release and never again
         single <= link.out_timing_true & link.out_timing_inv;
      end
   end

   // ------------------------------------------------------------
   // command decode
   // ------------------------------------------------------------
   wire start = k_t & ~link.bank_select_n;
   wire wr_cmd = start & ~link.read_not_write;
   wire rd_cmd = start & link.read_not_write;
   // narrow parts always begin the burst at offset 0
   wire [ADDR_W-1:0] base_addr = WIDE ? link.addr
                                      : {link.addr[ADDR_W-1:1], 1'b0};

   // ------------------------------------------------------------
   // storage
   // ------------------------------------------------------------
   logic [WORD_W-1:0] mem [2**ADDR_W];

   // write pipeline: command, first word, then completed pair in posting regs
   logic wp_pend;
   logic [ADDR_W-1:0] wp_addr;
   logic ws_valid;
   logic [ADDR_W-1:0] ws_addr;
   logic [WORD_W-1:0] ws_d0;
   logic [LANES-1:0] ws_m0;
   logic pv;
   logic [ADDR_W-1:0] pa;
   logic [WORD_W-1:0] pd [2];
   logic [LANES-1:0] pm [2];

   // read pipeline
   logic rp_pend;
   logic [ADDR_W-1:0] rp_addr;
   logic arm;
   logic [WORD_W-1:0] aw [2];
   logic w1p;
   logic [WORD_W-1:0] q1;
   logic [WORD_W-1:0] q;
   logic q_oe;

   wire commit = k_c & ws_valid;
   wire [ADDR_W-1:0] pa_pair [2];
   wire [ADDR_W-1:0] ra [2];
   wire [WORD_W-1:0] cm [2];
   wire [WORD_W-1:0] rd [2];
   assign pa_pair[0] = pa;
   assign pa_pair[1] = {pa[ADDR_W-1:1], ~pa[0]};
   assign ra[0] = rp_addr;
   assign ra[1] = {rp_addr[ADDR_W-1:1], ~rp_addr[0]};

   for (genvar i = 0; i < 2; i++) begin : g_word
      // a read of the posted pair takes the newest lanes from the posting regs
      wire hit = pv & (ra[i][ADDR_W-1:1] == pa[ADDR_W-1:1]);
      wire sel0 = ra[i][0] == pa[0];
      wire [WORD_W-1:0] pnew = sel0 ? pd[0] : pd[1];
      wire [LANES-1:0] pmask = hit ? (sel0 ? pm[0] : pm[1]) : KEEP_ALL;
      dtwbsp_lane_merge #(.WORD_W(WORD_W), .LANES(LANES)) u_commit (
         .old_i(mem[pa_pair[i]]),
         .new_i(pd[i]),
         .mask_n_i(pm[i]),
         .merged_o(cm[i])
      );
      dtwbsp_lane_merge #(.WORD_W(WORD_W), .LANES(LANES)) u_bypass (
         .old_i(mem[ra[i]]),
         .new_i(pnew),
         .mask_n_i(pmask),
         .merged_o(rd[i])
      );
   end

   // the older posted pair reaches the array only when a newer pair completes
   always_ff @(posedge clk_i) begin
      if (commit && pv) begin
         mem[pa_pair[0]] <= cm[0];
         mem[pa_pair[1]] <= cm[1];
      end
   end

   // ------------------------------------------------------------
   // write path
   // ------------------------------------------------------------
   always_ff @(posedge clk_i or posedge reset_i) begin
      if (reset_i) begin
         wp_pend <= 1'b0;
         wp_addr <= '0;
         ws_valid <= 1'b0;
         ws_addr <= '0;
         ws_d0 <= '0;
         ws_m0 <= '1;
         pv <= 1'b0;
         pa <= '0;
         pd <= '{default: '0};
         pm <= '{default: '1};
      end else begin
         if (k_t) begin
            wp_pend <= wr_cmd;
            if (wr_cmd) begin
               wp_addr <= base_addr;
            end
         end
         if (k_t && wp_pend) begin
            ws_valid <= 1'b1;
            ws_addr <= wp_addr;
            ws_d0 <= link.write_bits;
            ws_m0 <= link.lane_mask_n;
         end else if (k_c) begin
            ws_valid <= 1'b0;
         end
         if (commit) begin
            pv <= 1'b1;
            pa <= ws_addr;
            pd[0] <= ws_d0;
            pm[0] <= ws_m0;
            pd[1] <= link.write_bits;
            pm[1] <= link.lane_mask_n;
         end
      end
   end

   // ------------------------------------------------------------
   // read path and output drivers
   // ------------------------------------------------------------
   always_ff @(posedge clk_i or posedge reset_i) begin
      if (reset_i) begin
         rp_pend <= 1'b0;
         rp_addr <= '0;
         arm <= 1'b0;
         aw <= '{default: '0};
         w1p <= 1'b0;
         q1 <= '0;
         q <= '0;
         q_oe <= 1'b0;
      end else begin
         if (k_t) begin
            rp_pend <= rd_cmd;
            if (rd_cmd) begin
               rp_addr <= base_addr;
            end
         end
         // the array is read one input cycle after the command
         if (k_t && rp_pend) begin
            arm <= 1'b1;
            aw <= rd;
         end else if (c_i) begin
            arm <= 1'b0;
         end
         if (c_i && arm) begin
            q <= aw[0];
            q_oe <= 1'b1;
            q1 <= aw[1];
            w1p <= 1'b1;
         end else if (c_t) begin // pins hold while output clocks stop
            if (w1p) begin
               q <= q1;
               w1p <= 1'b0;
            end else begin
               // no burst left: release so the next bank can drive at once
               q_oe <= 1'b0;
            end
         end
      end
   end
   assign link.read_word = q;
   assign link.read_word_oe = q_oe;

   // ------------------------------------------------------------
   // echo strobes
   // ------------------------------------------------------------
   logic echo_t;
   logic echo_i;
   always_ff @(posedge clk_i or posedge reset_i) begin
      if (reset_i) begin
         echo_t <= 1'b0;
         echo_i <= 1'b0;
      end else begin
         echo_t <= c_t;
         echo_i <= c_i;
      end
   end
   assign link.echo_strobe_true = echo_t;
   assign link.echo_strobe_inv = echo_i;

   // ------------------------------------------------------------
   // impedance update and delay-locked loop status
   // ------------------------------------------------------------
   logic [IMP_CNT_W-1:0] imp_cnt;
   logic [GAP_CNT_W-1:0] gap;
   logic [GAP_CNT_W-1:0] lock_cnt;
   wire gap_long = gap > GAP_CNT_W'(DLL_RESET_CYC);
   wire gap_ok = gap <= GAP_CNT_W'(DLL_MAX_PERIOD_CYC);

   always_ff @(posedge clk_i or posedge reset_i) begin
      if (reset_i) begin
         imp_cnt <= '0;
         imp_update_o <= 1'b0;
         gap <= '0;
         lock_cnt <= '0;
         dll_locked_o <= 1'b0;
         single_clock_o <= 1'b0;
      end else begin
         single_clock_o <= single;
         imp_update_o <= 1'b0;
         if (k_t) begin
            imp_cnt <= imp_cnt + 1'b1;
            if (imp_cnt == IMP_CNT_W'(IMP_INTERVAL - 1)) begin
               imp_update_o <= 1'b1;
            end
         end
         // gap holds the cycles since the last input clock rise, saturating
         if (k_t) begin
            gap <= GAP_CNT_W'(1);
         end else if (!(&gap)) begin
            gap <= gap + 1'b1;
         end
         if (!link.loop_bypass_n || gap_long) begin
            lock_cnt <= '0;
            dll_locked_o <= 1'b0;
         end else if (k_t && gap_ok) begin
            // within the low frequency limit: count input clock rises until the loop locks
            if (lock_cnt == GAP_CNT_W'(DLL_LOCK_EDGES)) begin
               dll_locked_o <= 1'b1;
            end else begin
               lock_cnt <= lock_cnt + 1'b1;
            end
         end
      end
   end
endmodule

// ==== verilog/dtwbsp_host.sv ====
// controller end: makes the input and output clocks, issues commands, moves burst data
`timescale 1ns/100ps
module dtwbsp_host import dtwbsp_pkg::*; #(
   parameter int WORD_W = DEF_WORD_W,
   parameter int LANES = DEF_LANES,
   parameter int ADDR_W = DEF_ADDR_W,
   parameter bit SINGLE_CLOCK = 1'b0,
   parameter bit LOOP_BYPASS = 1'b0
) (
   // clock and reset
   input wire logic clk_i,
   input wire logic reset_i,
   // pins
   dtwbsp_if.host link,
   // command port
   input wire logic cmd_valid_i,
   input wire logic cmd_write_i,
   input wire logic [ADDR_W-1:0] cmd_addr_i,
   input wire logic [WORD_W-1:0] cmd_wdata0_i,
   input wire logic [WORD_W-1:0] cmd_wdata1_i,
   input wire logic [LANES-1:0] cmd_mask0_i,
   input wire logic [LANES-1:0] cmd_mask1_i,
   input wire logic dll_reset_i,
   output logic cmd_ready_o,
   // read answer
   output logic rd_valid_o,
   output logic [WORD_W-1:0] rd_data_o
);
   // ------------------------------------------------------------
   // clock generation
   // ------------------------------------------------------------
   logic ph;
   logic [GAP_CNT_W-1:0] st;
   logic req;
   logic [2:0] wsh;
   logic [RD_PIPE-1:0] rsh;
   logic k_t;
   logic k_c;
   wire busy = (|wsh) | (|rsh);
   wire prep = !ph && st == '0;
   wire take = prep && cmd_valid_i && cmd_ready_o;
   // a clock stretch only starts on an idle slot, never inside a burst
   wire stretch = prep && req && !take && !busy;
   // two idle slots after a read let its pins release before any write data
   wire next_ready = ((ph && st == '0) || st == GAP_CNT_W'(1)) && !req && !dll_reset_i
                     && !(|rsh[RD_W0_STAGE-1:0]);

   always_ff @(posedge clk_i or posedge reset_i) begin
      if (reset_i) begin
         ph <= 1'b0;
         st <= '0;
         req <= 1'b0;
         k_t <= 1'b0;
         k_c <= 1'b0;
         cmd_ready_o <= 1'b0;
      end else begin
         req <= (req && !stretch) || dll_reset_i;
         cmd_ready_o <= next_ready;
         if (stretch) begin
            st <= GAP_CNT_W'(DLL_RESET_CYC);
            k_t <= 1'b0;
            k_c <= 1'b0;
         end else if (st != '0) begin
            st <= st - 1'b1;
            k_t <= 1'b0;
            k_c <= 1'b0;
         end else begin
            ph <= ~ph;
            k_t <= ~ph;
            k_c <= ph;
         end
      end
   end
   assign link.sys_timing_true = k_t;
   assign link.sys_timing_comp = k_c;
   // zero-skew output clocks, or both held high as the single-clock strap
   assign link.out_timing_true = SINGLE_CLOCK | k_t;
   assign link.out_timing_inv = SINGLE_CLOCK | k_c;
   assign link.loop_bypass_n = ~LOOP_BYPASS;

   // ------------------------------------------------------------
   // command and write data
   // ------------------------------------------------------------
   logic bsel_n;
   logic rnw;
   logic [ADDR_W-1:0] addr;
   logic [WORD_W-1:0] hw0;
   logic [WORD_W-1:0] hw1;
   logic [LANES-1:0] hm0;
   logic [LANES-1:0] hm1;
   logic [WORD_W-1:0] hw1_s;
   logic [LANES-1:0] hm1_s;
   logic [WORD_W-1:0] d;
   logic [LANES-1:0] m;
   logic d_oe;

   always_ff @(posedge clk_i or posedge reset_i) begin
      if (reset_i) begin
         bsel_n <= 1'b1;
         rnw <= 1'b1;
         addr <= '0;
         wsh <= '0;
         hw0 <= '0;
         hw1 <= '0;
         hm0 <= '1;
         hm1 <= '1;
         hw1_s <= '0;
         hm1_s <= '1;
         d <= '0;
         m <= '1;
         d_oe <= 1'b0;
      end else begin
         // this device owns its own select line; other banks get their own
         bsel_n <= ~take;
         if (take) begin
            rnw <= ~cmd_write_i;
            addr <= cmd_addr_i;
         end
         if (take && cmd_write_i) begin
            hw0 <= cmd_wdata0_i;
            hw1 <= cmd_wdata1_i;
            hm0 <= cmd_mask0_i;
            hm1 <= cmd_mask1_i;
         end
         wsh <= {wsh[1:0], take && cmd_write_i};
         d_oe <= wsh[1] | wsh[2];
         if (wsh[1]) begin
            d <= hw0;
            m <= hm0;
            hw1_s <= hw1;
            hm1_s <= hm1;
         end else if (wsh[2]) begin
            d <= hw1_s;
            m <= hm1_s;
         end else begin
            m <= '1;
         end
      end
   end
   assign link.bank_select_n = bsel_n;
   assign link.read_not_write = rnw;
   assign link.addr = addr;
   assign link.write_bits = d;
   assign link.write_bits_oe = d_oe;
   assign link.lane_mask_n = m;

   // ------------------------------------------------------------
   // read capture
   // ------------------------------------------------------------
   wire cap = rsh[RD_W0_STAGE] | rsh[RD_W0_STAGE+1];
   always_ff @(posedge clk_i or posedge reset_i) begin
      if (reset_i) begin
         rsh <= '0;
         rd_valid_o <= 1'b0;
         rd_data_o <= '0;
      end else begin
         rsh <= {rsh[RD_PIPE-2:0], take && !cmd_write_i};
         rd_valid_o <= cap;
         if (cap) begin
            rd_data_o <= link.read_word;
         end
      end
   end
endmodule

// ==== verilog/dtwbsp_if.sv ====
// pin bundle between the memory controller and the sram port
`timescale 1ns/100ps
interface dtwbsp_if #(
   parameter int WORD_W = 18,
   parameter int LANES = 2,
   parameter int ADDR_W = 8
);
   logic sys_timing_true;
   logic sys_timing_comp;
   logic out_timing_true;
   logic out_timing_inv;
   logic bank_select_n;
   logic read_not_write;
   logic [ADDR_W-1:0] addr;
   logic [WORD_W-1:0] write_bits;
   logic write_bits_oe;
   logic [LANES-1:0] lane_mask_n;
   logic [WORD_W-1:0] read_word;
   logic read_word_oe;
   logic echo_strobe_true;
   logic echo_strobe_inv;
   logic loop_bypass_n;
   // level of the shared data pins, derived from the read enable alone
   logic [WORD_W-1:0] data_level;
   assign data_level = read_word_oe ? read_word : write_bits;

   modport dev (
      input sys_timing_true, sys_timing_comp, out_timing_true, out_timing_inv,
      input bank_select_n, read_not_write, addr, write_bits, lane_mask_n, loop_bypass_n,
      output read_word, read_word_oe, echo_strobe_true, echo_strobe_inv
   );
   modport host (
      output sys_timing_true, sys_timing_comp, out_timing_true, out_timing_inv,
      output bank_select_n, read_not_write, addr, write_bits, write_bits_oe, lane_mask_n,
      output loop_bypass_n,
      input read_word, read_word_oe, echo_strobe_true, echo_strobe_inv
   );
endinterface

// ==== verilog/dtwbsp_lane_merge.sv ====
// per-lane merge of new data over old data under an active-low mask
`timescale 1ns/100ps
module dtwbsp_lane_merge #(
   parameter int WORD_W = 18,
   parameter int LANES = 2
) (
   // data in
   input wire logic [WORD_W-1:0] old_i,
   input wire logic [WORD_W-1:0] new_i,
   input wire logic [LANES-1:0] mask_n_i,
   // data out
   output logic [WORD_W-1:0] merged_o
);
   localparam int LANE_W = WORD_W / LANES;
   for (genvar i = 0; i < LANES; i++) begin : g_lane
      // a high mask bit keeps the old lane
      assign merged_o[i*LANE_W +: LANE_W] = mask_n_i[i] ? old_i[i*LANE_W +: LANE_W]
                                                        : new_i[i*LANE_W +: LANE_W];
   end
endmodule

// ==== verilog/dtwbsp_pkg.sv ====
// constants shared by both ends of the two-word burst ddr sram port
package dtwbsp_pkg;
   // ------------------------------------------------------------
   // geometry
   // ------------------------------------------------------------
   localparam int DEF_WORD_W = 18;
   localparam int DEF_LANES = 2;
   localparam int DEF_ADDR_W = 8;
   localparam int NARROW_W = 8;
   // ------------------------------------------------------------
   // timing
   // ------------------------------------------------------------
   localparam int CLK_PERIOD_NS = 5;
   localparam int IMP_INTERVAL = 1024;
   localparam int IMP_CNT_W = 10;
   localparam int DLL_MIN_MHZ = 80;
   localparam int DLL_MAX_PERIOD_CYC = 1000 / (DLL_MIN_MHZ * CLK_PERIOD_NS);
   localparam int DLL_RESET_NS = 30;
   localparam int DLL_RESET_CYC = DLL_RESET_NS / CLK_PERIOD_NS;
   localparam int DLL_LOCK_EDGES = 4;
   localparam int GAP_CNT_W = 4;
   // read words seen on the pins this many cycles after the command slot
   localparam int RD_PIPE = 6;
   localparam int RD_W0_STAGE = 4;
endpackage
